// [rtl/dma_controller.sv]
// eight-channel dma engine with an apb register port
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none
module dma_controller (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [127:0]        irq_lines,
   input  wire logic [127:0]        ram_addr_lines,
   output var dma_pkg::bus_req_type ram_req,
   input  wire logic [15:0]         ram_rdata,
   input  wire logic                ram_collide,
   output var dma_pkg::bus_req_type periph_req,
   input  wire logic [15:0]         periph_rdata,
   input  wire logic                periph_collide,
   output logic [7:0]               channel_irq_flag
);
   localparam int n = dma_pkg::num_channels;
   typedef enum logic [2:0] {idle, do_read, wait_data, do_write, done} state_type;

   logic [15:0] channel_setup_reg      [n];
   logic [15:0] trigger_select_reg     [n];
   logic [15:0] buffer_a_base_reg      [n];
   logic [15:0] buffer_b_base_reg      [n];
   logic [15:0] peripheral_pointer_reg [n];
   logic [9:0]  block_length_reg       [n];
   logic [15:0] ram_pointer            [n];
   logic [9:0]  done_count             [n];
   logic [7:0]  ping_pong_select;
   logic [7:0]  ram_write_collision;
   logic [7:0]  periph_write_collision;
   logic [3:0]  last_active_channel;
   logic [15:0] recent_ram_addr;
   logic [127:0] irq_meta;
   logic [127:0] irq_sync;
   logic [127:0] irq_prev;
   logic [7:0]  pending;
   logic [7:0]  triggered;
   state_type   state;
   logic [2:0]  active;
   logic [15:0] data_hold;
   logic [15:0] xfer_ram_addr;
   logic        block_end;
   logic        half_point;
   logic        chan_done_pulse;
   logic        collide_window;

   // decoded apb access
   logic        apb_access;
   logic        apb_write;
   logic        chan_hit;
   logic [2:0]  chan_sel;
   logic [4:0]  chan_off;
   assign apb_access = psel && penable && !pready;
   assign apb_write  = apb_access && pwrite;
   assign chan_hit   = paddr < (chan_stride_total());
   assign chan_sel   = paddr[7:5];
   assign chan_off   = paddr[4:0];

   function automatic logic [11:0] chan_stride_total();
      chan_stride_total = 12'(n) * dma_pkg::chan_stride;
   endfunction

   function automatic logic [15:0] start_of(input logic [2:0] c, input logic b_sel);
      start_of = b_sel ? buffer_b_base_reg[c] : buffer_a_base_reg[c];
   endfunction

   function automatic logic pp_mode(input logic [1:0] m);
      pp_mode = (m == dma_pkg::om_cont_pp) || (m == dma_pkg::om_one_pp);
   endfunction

   // request edge detection sees only the second synchroniser stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_meta <= '0;
         irq_sync <= '0;
         irq_prev <= '0;
      end else begin
         irq_meta <= irq_lines;
         irq_sync <= irq_meta;
         irq_prev <= irq_sync;
      end
   end

   always_comb begin
      for (int c = 0; c < n; c++) begin
         triggered[c] = irq_sync[trigger_select_reg[c][6:0]]
                        && !irq_prev[trigger_select_reg[c][6:0]];
      end
   end

   // pending latch: trigger set wins over service clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= '0;
      end else begin
         for (int c = 0; c < n; c++) begin
            if (!channel_setup_reg[c][dma_pkg::bit_on]) begin
               pending[c] <= 1'b0;
            end else if (triggered[c]) begin
               pending[c] <= 1'b1;
            end else if (state == done && active == 3'(c)) begin
               // force drops at this same edge, so it must not re-arm here
               pending[c] <= 1'b0;
            end else if (trigger_select_reg[c][dma_pkg::bit_force]) begin
               pending[c] <= 1'b1;
            end
         end
      end
   end

   // transfer engine, one transfer at a time on its own bus
   assign xfer_ram_addr = (channel_setup_reg[active][5:4] > dma_pkg::am_fixed)
                          ? ram_addr_lines[trigger_select_reg[active][3:0]*8 +: 16]
                          : ram_pointer[active];
   assign block_end  = done_count[active] == block_length_reg[active];
   assign half_point = done_count[active] == (block_length_reg[active] >> 1);
   // read data stands one cycle only, so it feeds the write directly
   assign data_hold  = channel_setup_reg[active][dma_pkg::bit_dir]
                       ? ram_rdata : periph_rdata;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= idle;
         active    <= '0;
         ram_req   <= '0;
         periph_req <= '0;
      end else begin
         ram_req.valid    <= 1'b0;
         periph_req.valid <= 1'b0;
         case (state)
            idle: begin
               for (int c = n - 1; c >= 0; c--) begin
                  if (pending[c]) begin
                     active <= 3'(c);
                  end
               end
               if (|pending) begin
                  state <= do_read;
               end
            end
            do_read: begin
               state <= wait_data;
            end
            wait_data: begin
               // far side answers one cycle after the read strobe
               state <= do_write;
            end
            do_write: begin
               if (channel_setup_reg[active][dma_pkg::bit_dir]) begin
                  periph_req <= '{1'b1, 1'b1, channel_setup_reg[active][dma_pkg::bit_byte],
                                  peripheral_pointer_reg[active], data_hold};
               end else begin
                  ram_req <= '{1'b1, 1'b1, channel_setup_reg[active][dma_pkg::bit_byte],
                               xfer_ram_addr, data_hold};
                  if (channel_setup_reg[active][dma_pkg::bit_null]) begin
                     periph_req <= '{1'b1, 1'b1, channel_setup_reg[active][dma_pkg::bit_byte],
                                     peripheral_pointer_reg[active], 16'h0000};
                  end
               end
               state <= done;
            end
            done: begin
               state <= idle;
            end
            default: begin
               state <= idle;
            end
         endcase
         if (state == do_read) begin
            // read strobes go out in the read cycle
            if (channel_setup_reg[active][dma_pkg::bit_dir]) begin
               ram_req <= '{1'b1, 1'b0, channel_setup_reg[active][dma_pkg::bit_byte],
                            xfer_ram_addr, 16'h0000};
            end else begin
               periph_req <= '{1'b1, 1'b0, channel_setup_reg[active][dma_pkg::bit_byte],
                               peripheral_pointer_reg[active], 16'h0000};
            end
         end
      end
   end

   assign chan_done_pulse = state == done;

   // collide answers arrive a cycle after the write strobe, so sample them late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         collide_window <= 1'b0;
      end else begin
         collide_window <= chan_done_pulse;
      end
   end

   // completion pulses toward the interrupt controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_irq_flag <= '0;
      end else begin
         channel_irq_flag <= '0;
         if (chan_done_pulse) begin
            channel_irq_flag[active] <= channel_setup_reg[active][dma_pkg::bit_half]
                                        ? half_point : block_end;
         end
      end
   end

   // pointers, counts, ping-pong and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < n; c++) begin
            ram_pointer[c] <= '0;
            done_count[c]  <= '0;
         end
         ping_pong_select       <= '0;
         last_active_channel    <= dma_pkg::no_channel;
         recent_ram_addr        <= '0;
         ram_write_collision    <= '0;
         periph_write_collision <= '0;
      end else begin
         if (apb_write && chan_hit && chan_off == dma_pkg::reg_base_a) begin
            ram_pointer[chan_sel] <= pwdata[15:0];
            ping_pong_select[chan_sel] <= 1'b0;
            done_count[chan_sel] <= '0;
         end
         if (chan_done_pulse) begin
            last_active_channel <= {1'b0, active};
            recent_ram_addr     <= xfer_ram_addr;
            if (block_end) begin
               done_count[active] <= '0;
               if (pp_mode(channel_setup_reg[active][1:0])) begin
                  ping_pong_select[active] <= !ping_pong_select[active];
                  ram_pointer[active] <= start_of(active, !ping_pong_select[active]);
               end else begin
                  ram_pointer[active] <= start_of(active, 1'b0);
               end
            end else begin
               done_count[active] <= done_count[active] + 10'h001;
               if (channel_setup_reg[active][5:4] == dma_pkg::am_postinc) begin
                  ram_pointer[active] <= ram_pointer[active]
                     + (channel_setup_reg[active][dma_pkg::bit_byte]
                        ? dma_pkg::step_byte : dma_pkg::step_word);
               end
            end
         end
         // collision flags: set wins, software writes 0 to clear
         for (int c = 0; c < n; c++) begin
            if (apb_write && paddr == dma_pkg::reg_collision && !pwdata[c]) begin
               ram_write_collision[c] <= 1'b0;
            end
            if (apb_write && paddr == dma_pkg::reg_collision && !pwdata[c + 8]) begin
               periph_write_collision[c] <= 1'b0;
            end
         end
         if (collide_window && ram_collide && !channel_setup_reg[active][dma_pkg::bit_dir]) begin
            ram_write_collision[active] <= 1'b1;
         end
         if (collide_window && periph_collide
             && (channel_setup_reg[active][dma_pkg::bit_dir]
                 || channel_setup_reg[active][dma_pkg::bit_null])) begin
            periph_write_collision[active] <= 1'b1;
         end
      end
   end

   // software-visible channel registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < n; c++) begin
            channel_setup_reg[c]      <= '0;
            trigger_select_reg[c]     <= '0;
            buffer_a_base_reg[c]      <= '0;
            buffer_b_base_reg[c]      <= '0;
            peripheral_pointer_reg[c] <= '0;
            block_length_reg[c]       <= '0;
         end
      end else begin
         if (apb_write && chan_hit) begin
            case (chan_off)
               dma_pkg::reg_setup:  channel_setup_reg[chan_sel] <= pwdata[15:0]
                                                              & dma_pkg::setup_mask;
               dma_pkg::reg_trigger: begin
                  trigger_select_reg[chan_sel][6:0] <= pwdata[6:0];
                  if (pwdata[dma_pkg::bit_force]) begin
                     trigger_select_reg[chan_sel][dma_pkg::bit_force] <= 1'b1;
                  end
               end
               dma_pkg::reg_base_a: buffer_a_base_reg[chan_sel] <= pwdata[15:0];
               dma_pkg::reg_base_b: buffer_b_base_reg[chan_sel] <= pwdata[15:0];
               dma_pkg::reg_periph: peripheral_pointer_reg[chan_sel] <= pwdata[15:0];
               dma_pkg::reg_length: block_length_reg[chan_sel] <= pwdata[9:0]
                                                              & dma_pkg::tally_mask;
               default: ;
            endcase
         end
         if (chan_done_pulse) begin
            // clearing follows the force service even on a same-cycle rewrite
            if (trigger_select_reg[active][dma_pkg::bit_force]) begin
               trigger_select_reg[active][dma_pkg::bit_force] <= 1'b0;
            end
            if (block_end && (channel_setup_reg[active][1:0] == dma_pkg::om_oneshot
                || (channel_setup_reg[active][1:0] == dma_pkg::om_one_pp
                    && ping_pong_select[active]))) begin
               channel_setup_reg[active][dma_pkg::bit_on] <= 1'b0;
            end
         end
      end
   end

   // apb slave: one wait state, errors on unmapped words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apb_access;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (apb_access) begin
            if (chan_hit) begin
               case (chan_off)
                  dma_pkg::reg_setup:   prdata <= {16'h0000, channel_setup_reg[chan_sel]};
                  dma_pkg::reg_trigger: prdata <= {16'h0000, trigger_select_reg[chan_sel]};
                  dma_pkg::reg_base_a,
                  dma_pkg::reg_base_b:  prdata <= {16'h0000, ram_pointer[chan_sel]};
                  dma_pkg::reg_periph:  prdata <= {16'h0000, peripheral_pointer_reg[chan_sel]};
                  dma_pkg::reg_length:  prdata <= {22'h000000, block_length_reg[chan_sel]};
                  default:              pslverr <= 1'b1;
               endcase
            end else if (paddr == dma_pkg::reg_collision) begin
               prdata <= {16'h0000, periph_write_collision, ram_write_collision};
            end else if (paddr == dma_pkg::reg_status) begin
               prdata <= {20'h00000, last_active_channel, ping_pong_select};
            end else if (paddr == dma_pkg::reg_recent) begin
               prdata <= {16'h0000, recent_ram_addr};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // dma_controller
`default_nettype wire

// [rtl/dma_pkg.sv]
// package: register map, field positions and bus types of the dma controller
`default_nettype none
package dma_pkg;
   localparam int          num_channels  = 8;
   localparam logic [11:0] chan_stride   = 12'h020;
   localparam logic [4:0]  reg_setup     = 5'h00;
   localparam logic [4:0]  reg_trigger   = 5'h04;
   localparam logic [4:0]  reg_base_a    = 5'h08;
   localparam logic [4:0]  reg_base_b    = 5'h0c;
   localparam logic [4:0]  reg_periph    = 5'h10;
   localparam logic [4:0]  reg_length    = 5'h14;
   localparam logic [11:0] reg_collision = 12'h100;
   localparam logic [11:0] reg_status    = 12'h104;
   localparam logic [11:0] reg_recent    = 12'h108;
   localparam int          bit_on        = 15;
   localparam int          bit_byte      = 14;
   localparam int          bit_dir       = 13;
   localparam int          bit_half      = 12;
   localparam int          bit_null      = 11;
   localparam int          bit_force     = 15;
   localparam logic [15:0] setup_mask    = 16'hf833;
   localparam logic [15:0] trigger_mask  = 16'h007f;
   localparam logic [9:0]  tally_mask    = 10'h3ff;
   localparam logic [1:0]  am_postinc    = 2'h0;
   localparam logic [1:0]  am_fixed      = 2'h1;
   localparam logic [1:0]  om_cont       = 2'h0;
   localparam logic [1:0]  om_oneshot    = 2'h1;
   localparam logic [1:0]  om_cont_pp    = 2'h2;
   localparam logic [1:0]  om_one_pp     = 2'h3;
   localparam logic [3:0]  no_channel    = 4'hf;
   localparam logic [15:0] step_byte     = 16'h0001;
   localparam logic [15:0] step_word     = 16'h0002;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_size;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_type;
endpackage
`default_nettype wire

// [verif/dma_controller_asserts.sv]
// checker module for the dma controller ports, bound to the design
`default_nettype none
module dma_checker (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire dma_pkg::bus_req_type ram_req,
   input wire dma_pkg::bus_req_type periph_req,
   input wire logic [15:0]          periph_rdata,
   input wire logic [7:0]           channel_irq_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pr;
   logic rr;
   assign pr = periph_req.valid && !periph_req.write;
   assign rr = ram_req.valid && !ram_req.write;

   a_apb_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("register port answer not after one wait cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error response without ready");
   a_req_pulse: assert property ((ram_req.valid || periph_req.valid) |=>
      !(ram_req.valid || periph_req.valid)) else $error("transfer request not a pulse");
   a_p2r_order: assert property (pr |-> ##2 (ram_req.valid && ram_req.write))
      else $error("peripheral read not followed by ram write");
   a_r2p_order: assert property (rr |-> ##2 (periph_req.valid && periph_req.write))
      else $error("ram read not followed by peripheral write");
   a_data_carry: assert property (pr |-> ##2 (ram_req.wdata[7:0] == $past(periph_rdata[7:0])))
      else $error("ram write data differs from peripheral data");
   a_size_keep: assert property (pr |-> ##2 (ram_req.byte_size == $past(periph_req.byte_size, 2)))
      else $error("transfer size changed inside a transfer");
   a_irq_cause: assert property (|channel_irq_flag |->
      $past((ram_req.valid && ram_req.write) || (periph_req.valid && periph_req.write)))
      else $error("completion pulse without a preceding write");
   a_irq_onehot: assert property ($onehot0(channel_irq_flag))
      else $error("two completion pulses at once");
   a_irq_pulse: assert property (|channel_irq_flag |=> channel_irq_flag == 8'h00)
      else $error("completion flag not a single pulse");

   c_p2r: cover property (pr);
   c_r2p: cover property (rr);
   c_irq: cover property (|channel_irq_flag);
   c_err: cover property (pslverr);
endmodule // dma_checker

bind dma_controller dma_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .ram_req(ram_req),
   .periph_req(periph_req), .periph_rdata(periph_rdata), .channel_irq_flag(channel_irq_flag));
`default_nettype wire

// [verif/dma_far_side.sv]
// partner model: peripheral registers and dual-port dma ram on the transfer bus
`default_nettype none
module dma_far_side (
   input  wire logic                 pclk,
   input  wire logic                 collide_on,
   input  wire dma_pkg::bus_req_type ram_req,
   input  wire dma_pkg::bus_req_type periph_req,
   output logic [15:0]               ram_rdata,
   output logic [15:0]               periph_rdata,
   output logic                      ram_collide,
   output logic                      periph_collide
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] ram_mem [logic [15:0]];
   logic [15:0] per_mem [logic [15:0]];
   logic [15:0] per_wr_q [$];
   initial begin
      ram_rdata = 16'h0000;
      periph_rdata = 16'h0000;
   end
   // read data valid one cycle only; inverted after so stale values never match
   always @(posedge pclk) begin
      ram_rdata <= (ram_req.valid && !ram_req.write) ? ram_mem[ram_req.addr] : ~ram_rdata;
      periph_rdata <= (periph_req.valid && !periph_req.write) ? per_mem[periph_req.addr]
                                                               : ~periph_rdata;
      ram_collide <= collide_on && ram_req.valid && ram_req.write;
      periph_collide <= collide_on && periph_req.valid && periph_req.write;
      if (ram_req.valid && ram_req.write) ram_mem[ram_req.addr] = ram_req.wdata;
      if (periph_req.valid && periph_req.write) begin
         per_mem[periph_req.addr] = periph_req.wdata;
         per_wr_q.push_back(periph_req.addr);
      end
   end
endmodule // dma_far_side
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the dma controller
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] r_set = dma_pkg::reg_setup;
   localparam logic [4:0] r_trg = dma_pkg::reg_trigger;
   localparam logic [4:0] r_a   = dma_pkg::reg_base_a;
   localparam logic [4:0] r_per = dma_pkg::reg_periph;
   localparam logic [4:0] r_len = dma_pkg::reg_length;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err, collide_on;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic [127:0]         irq_lines, ram_addr_lines;
   logic [15:0]          ram_rdata, periph_rdata;
   logic                 ram_collide, periph_collide;
   logic [7:0]           channel_irq_flag;
   dma_pkg::bus_req_type ram_req, periph_req;
   int                   n_fail, cmp_count, n0;
   int                   irq_n [8];

   dma_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_lines(irq_lines), .ram_addr_lines(ram_addr_lines),
      .ram_req(ram_req), .ram_rdata(ram_rdata), .ram_collide(ram_collide),
      .periph_req(periph_req), .periph_rdata(periph_rdata), .periph_collide(periph_collide),
      .channel_irq_flag(channel_irq_flag));
   dma_far_side far (.pclk(pclk), .collide_on(collide_on), .ram_req(ram_req),
      .periph_req(periph_req), .ram_rdata(ram_rdata), .periph_rdata(periph_rdata),
      .ram_collide(ram_collide), .periph_collide(periph_collide));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) for (int i = 0; i < 8; i++) irq_n[i] += int'(channel_irq_flag[i]);

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [11:0] ad(input int c, input logic [4:0] r);
      return 12'(c * 32) | {7'h00, r};
   endfunction
   // request held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int c, input logic [4:0] r, input logic [31:0] d);
      apb(1'b1, ad(c, r), d);
   endtask
   task automatic rc(input string what, input int c, input logic [4:0] r, input logic [31:0] e);
      apb(1'b0, ad(c, r), 32'h0);
      check(what, rd, e);
   endtask
   task automatic setup_ch(input int c, input logic [15:0] per, len, base);
      wr(c, r_per, {16'h0, per});
      wr(c, r_len, {16'h0, len});
      wr(c, r_a, {16'h0, base});
   endtask
   task automatic fire(input int c, input logic [6:0] code);
      int n;
      n = 0;
      wr(c, r_trg, {16'h0, 9'h100, code});
      do begin
         apb(1'b0, ad(c, r_trg), 32'h0);
         n++;
      end while (rd[15] !== 1'b0 && n < 20);
      if (n >= 20) n_fail++;
   endtask
   task automatic pulse(input int ln, input int c);
      @(posedge pclk);
      irq_lines[ln] <= 1'b1;
      repeat (4) @(posedge pclk);
      irq_lines[ln] <= 1'b0;
      for (int k = 0; k < 100 && irq_n[c] < 1; k++) @(posedge pclk);
   endtask

   initial begin
      #80000;
      n_fail++;
      final_report();
   end
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      irq_lines = '0;
      ram_addr_lines = '0;
      collide_on = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         rc("setup reset", c, r_set, 32'h0);
         rc("trigger reset", c, r_trg, 32'h0);
      end
      rc("status reset", 8, 5'h04, 32'h0f00);
      apb(1'b0, 12'h018, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      wr(3, r_set, 32'hffff);
      rc("setup fields", 3, r_set, 32'hf833);
      wr(3, r_set, 32'h0);
      $display("test reset and fields done");
      far.per_mem[16'h0226] = 16'h1234;
      setup_ch(0, 16'h0226, 16'h0001, 16'h0100);
      wr(0, r_set, 32'h8001);
      fire(0, 7'h0b);
      rc("force cleared", 0, r_trg, 32'h000b);
      check("ram word", {16'h0, far.ram_mem[16'h0100]}, 32'h1234);
      rc("live pointer", 0, r_a, 32'h0102);
      check("no early irq", irq_n[0], 32'h0);
      rc("last channel", 8, 5'h04, 32'h0000);
      fire(0, 7'h0b);
      for (int k = 0; k < 100 && irq_n[0] < 1; k++) @(posedge pclk);
      check("block irq", irq_n[0], 32'h1);
      rc("one-shot off", 0, r_set, 32'h0001);
      $display("test forced one-shot done");
      far.ram_mem[16'h0500] = 16'h00a1;
      far.ram_mem[16'h0600] = 16'h00a2;
      setup_ch(1, 16'h0182, 16'h0000, 16'h0500);
      setup_ch(2, 16'h0188, 16'h0000, 16'h0600);
      for (int c = 1; c < 3; c++) wr(c, r_trg, 32'h0005);
      for (int c = 1; c < 3; c++) wr(c, r_set, 32'ha010);
      far.per_wr_q.delete();
      pulse(5, 2);
      check("winner first", {16'h0, far.per_wr_q[0]}, 32'h0182);
      check("loser second", {16'h0, far.per_wr_q[1]}, 32'h0188);
      check("periph data", {16'h0, far.per_mem[16'h0188]}, 32'h00a2);
      rc("last channel", 8, 5'h04, 32'h0200);
      rc("still on", 1, r_set, 32'ha010);
      rc("reloaded", 2, r_a, 32'h0600);
      for (int c = 1; c < 3; c++) wr(c, r_set, 32'h0);
      $display("test priority done");
      far.per_mem[16'h0300] = 16'h12ab;
      setup_ch(4, 16'h0300, 16'h0003, 16'h0200);
      wr(4, dma_pkg::reg_base_b, 32'h0280);
      wr(4, r_set, 32'hd002);
      fire(4, 7'h0d);
      rc("byte step", 4, r_a, 32'h0201);
      check("byte data", {24'h0, far.ram_mem[16'h0200][7:0]}, 32'h00ab);
      check("no irq yet", irq_n[4], 32'h0);
      for (int k = 0; k < 3; k++) fire(4, 7'h0d);
      check("half irq only", irq_n[4], 32'h1);
      rc("buffer swap", 4, dma_pkg::reg_base_b, 32'h0280);
      rc("ping-pong state", 8, 5'h04, 32'h0410);
      wr(4, r_set, 32'h0);
      $display("test ping-pong done");
      far.per_mem[16'h0248] = 16'h1234;
      setup_ch(5, 16'h0248, 16'h0000, 16'h0700);
      wr(5, r_set, 32'h8801);
      n0 = far.per_wr_q.size();
      collide_on <= 1'b1;
      fire(5, 7'h0a);
      collide_on <= 1'b0;
      check("null write", far.per_wr_q.size(), n0 + 1);
      rc("collisions", 8, 5'h00, 32'h2020);
      wr(8, 5'h00, 32'h0);
      rc("collisions cleared", 8, 5'h00, 32'h0);
      $display("test null write done");
      ram_addr_lines[15:0] <= 16'h0440;
      far.per_mem[16'h0144] = 16'h5a5a;
      setup_ch(7, 16'h0144, 16'h0000, 16'h0100);
      wr(7, r_set, 32'h8021);
      pulse(0, 7);
      check("indirect ram", {16'h0, far.ram_mem[16'h0440]}, 32'h5a5a);
      rc("recent addr", 8, 5'h08, 32'h0440);
      setup_ch(6, 16'h0224, 16'h0000, 16'h0700);
      wr(6, r_trg, 32'h007f);
      wr(6, r_set, 32'ha001);
      pulse(127, 6);
      check("line 127", {16'h0, far.per_mem[16'h0224]}, 32'h1234);
      $display("test request lines done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
